// ---- sepr_defs.vh ----
// Constants shared by the serial EEPROM command and protection logic
`ifndef SEPR_DEFS_VH
`define SEPR_DEFS_VH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define SEPR_OP_WRITE_ENABLE  8'h06
`define SEPR_OP_WRITE_DISABLE 8'h04
`define SEPR_OP_STATUS_READ   8'h05
`define SEPR_OP_STATUS_WRITE  8'h01
`define SEPR_OP_ARRAY_READ    8'h03
`define SEPR_OP_ARRAY_WRITE   8'h02

// ----------------------------------------------------------------------
// Status byte layout and reset value
// ----------------------------------------------------------------------
`define SEPR_SB_BUSY          0
`define SEPR_SB_LATCH         1
`define SEPR_SB_GUARD_LO      2
`define SEPR_SB_GUARD_HI      3
`define SEPR_SB_LOCK          7
`define SEPR_STATUS_RST       8'h00

// ----------------------------------------------------------------------
// Guarded region encodings and boundaries
// ----------------------------------------------------------------------
`define SEPR_GUARD_NONE       2'b00
`define SEPR_GUARD_QUARTER    2'b01
`define SEPR_GUARD_HALF       2'b10
`define SEPR_GUARD_ALL        2'b11
`define SEPR_QUARTER_BASE     16'hc000
`define SEPR_HALF_BASE        16'h8000

// ----------------------------------------------------------------------
// Timing: self-timed write cycle, least time rounded up to clocks
// ----------------------------------------------------------------------
`define SEPR_CLK_NS           20
`define SEPR_TW_US            1000
`define SEPR_TW_CYC           ((`SEPR_TW_US * 1000 + `SEPR_CLK_NS - 1) / `SEPR_CLK_NS)

`endif

// ---- sepr_sync.v ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module sepr_sync #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input  wire             clock_i,
  input  wire             resetn_i,
  // Asynchronous inputs and their reset levels
  input  wire [WIDTH-1:0] async_i,
  input  wire [WIDTH-1:0] rst_val_i,
  // Synchronised levels
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage; both start at the idle levels
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      meta_q <= rst_val_i;
      sync_q <= rst_val_i;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  // Idle levels are forced during reset so no false edge follows release
  assign sync_o = resetn_i ? sync_q : rst_val_i;

endmodule

`default_nettype wire

// ---- sepr_cycle_timer.v ----
// Self-timed write cycle counter
`timescale 1ns/1ps
`default_nettype none

module sepr_cycle_timer #(
  parameter CW     = 24,
  parameter CYCLES = 50000
) (
  // Clock and reset
  input  wire clock_i,
  input  wire resetn_i,
  // Control
  input  wire start_i,
  // Status
  output wire busy_o,
  output wire done_o
);

  localparam [31:0]   LAST_W = CYCLES - 1;
  localparam [CW-1:0] LAST   = LAST_W[CW-1:0];

  reg          busy_q;
  reg [CW-1:0] cnt_q;

  // Busy for exactly CYCLES clocks; start while busy is ignored
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      busy_q <= 1'b0;
      cnt_q  <= {CW{1'b0}};
    end else if (!busy_q) begin
      busy_q <= start_i;
      cnt_q  <= {CW{1'b0}};
    end else if (cnt_q == LAST) begin
      busy_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_q + 1'b1;
    end
  end

  assign busy_o = busy_q;
  assign done_o = busy_q && (cnt_q == LAST);

endmodule

`default_nettype wire

// ---- sepr_command_protect.v ----
// Serial EEPROM command decoder, write latch and status protection
`timescale 1ns/1ps
`default_nettype none
`include "sepr_defs.vh"

module sepr_command_protect #(
  parameter TW_CYCLES = `SEPR_TW_CYC,
  parameter TW_CW     = 24
) (
  // Clock and reset
  input  wire        clock_i,
  input  wire        resetn_i,
  // Serial bus pins
  input  wire        spi_sclk_i,
  input  wire        spi_cs_n_i,
  input  wire        spi_mosi_i,
  output wire        spi_miso_o,
  output wire        spi_miso_oe_o,
  // Protect pin
  input  wire        write_protect_n_i,
  // Array write hand-off
  output wire        array_wr_go_o,
  output wire [15:0] array_wr_addr_o,
  output wire [7:0]  array_wr_byte_o,
  output wire        array_wr_byte_vld_o,
  // Status view
  output wire [7:0]  status_o,
  output wire        hw_lock_o
);

  // --------------------------------------------------------------------
  // States, one-hot
  // --------------------------------------------------------------------
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_OPC  = 8'h02;
  localparam [7:0] ST_SRD  = 8'h04;
  localparam [7:0] ST_SWR  = 8'h08;
  localparam [7:0] ST_ADR  = 8'h10;
  localparam [7:0] ST_DAT  = 8'h20;
  localparam [7:0] ST_WAIT = 8'h40;
  localparam [7:0] ST_IGN  = 8'h80;

  // Delivery state of the status byte, indexed by field position
  localparam [7:0] STATUS_RST = `SEPR_STATUS_RST;

  // --------------------------------------------------------------------
  // Guard decode
  // --------------------------------------------------------------------
  function guarded;
    input [15:0] addr;
    input [1:0]  guard;
    begin
      case (guard)
        `SEPR_GUARD_NONE:    guarded = 1'b0;
        `SEPR_GUARD_QUARTER: guarded = (addr >= `SEPR_QUARTER_BASE);
        `SEPR_GUARD_HALF:    guarded = (addr >= `SEPR_HALF_BASE);
        default:             guarded = 1'b1;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Pin synchronisation and edge detection
  // --------------------------------------------------------------------
  wire [3:0] pins_s;
  wire       sclk_s;
  wire       cs_n_s;
  wire       mosi_s;
  wire       wp_n_s;

  // Reset levels: chip select and protect idle high
  sepr_sync #(
    .WIDTH (4)
  ) u_sync (
    .clock_i   (clock_i),
    .resetn_i  (resetn_i),
    .async_i   ({write_protect_n_i, spi_mosi_i, spi_cs_n_i, spi_sclk_i}),
    .rst_val_i (4'ha),
    .sync_o    (pins_s)
  );

  assign sclk_s = pins_s[0];
  assign cs_n_s = pins_s[1];
  assign mosi_s = pins_s[2];
  assign wp_n_s = pins_s[3];

  reg sclk_d_q;
  reg cs_n_d_q;

  // Previous levels for edge finding
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      sclk_d_q <= 1'b0;
      cs_n_d_q <= 1'b1;
    end else begin
      sclk_d_q <= sclk_s;
      cs_n_d_q <= cs_n_s;
    end
  end

  // Sampling on the rise and launching on the fall holds for both idle levels
  wire sclk_rise = sclk_s & ~sclk_d_q;
  wire sclk_fall = ~sclk_s & sclk_d_q;
  wire cs_fall   = ~cs_n_s & cs_n_d_q;
  wire cs_rise   = cs_n_s & ~cs_n_d_q;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg [7:0]  state_q;
  reg [2:0]  bit_q;
  reg [7:0]  in_sh_q;
  reg [7:0]  cmd_q;
  reg        adr_hi_q;
  reg        got_data_q;
  reg [15:0] addr_q;
  reg [7:0]  pend_q;
  reg        wr_kind_q;
  reg        latch_q;
  reg        lock_q;
  reg [1:0]  guard_q;
  reg        go_q;
  reg [7:0]  byte_q;
  reg        byte_vld_q;
  reg        miso_q;
  reg [7:0]  osh_q;
  reg [2:0]  out_cnt_q;

  wire       busy;
  wire       done;
  wire [7:0] in_byte  = {in_sh_q[6:0], mosi_s};
  wire       byte_end = sclk_rise && (bit_q == 3'd7);

  // Lock mode tracks pin and bit levels, so order of events is irrelevant
  wire hw_lock = lock_q & ~wp_n_s;

  // Status byte; unused bits tie to zero
  wire [7:0] status = {lock_q, 3'b000, guard_q, latch_q, busy};

  // Acceptance checks evaluated at the chip select rise
  wire swr_ok = latch_q & ~busy & ~hw_lock;
  wire awr_ok = got_data_q && (bit_q == 3'd0) && latch_q && !busy &&
                !guarded(addr_q, guard_q);

  wire start_swr = cs_rise && (state_q == ST_WAIT) &&
                   (cmd_q == `SEPR_OP_STATUS_WRITE) && swr_ok;
  wire start_awr = cs_rise && (state_q == ST_DAT) && awr_ok;

  // --------------------------------------------------------------------
  // Self-timed write cycle
  // --------------------------------------------------------------------
  sepr_cycle_timer #(
    .CW     (TW_CW),
    .CYCLES (TW_CYCLES)
  ) u_timer (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .start_i  (start_swr | start_awr),
    .busy_o   (busy),
    .done_o   (done)
  );

  // --------------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------------
  // Chip select rise wins over a clock edge in the same cycle
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      state_q    <= ST_IDLE;
      bit_q      <= 3'd0;
      in_sh_q    <= 8'h00;
      cmd_q      <= 8'h00;
      adr_hi_q   <= 1'b0;
      got_data_q <= 1'b0;
      addr_q     <= 16'h0000;
      pend_q     <= 8'h00;
      byte_q     <= 8'h00;
      byte_vld_q <= 1'b0;
    end else begin
      byte_vld_q <= 1'b0;
      if (cs_rise) begin
        state_q <= ST_IDLE;
      end else if (cs_fall) begin
        // Only a falling edge selects; a select held low through reset reads as a fall after release
        state_q    <= ST_OPC;
        bit_q      <= 3'd0;
        adr_hi_q   <= 1'b0;
        got_data_q <= 1'b0;
      end else if (sclk_rise && (state_q != ST_IDLE)) begin
        bit_q   <= bit_q + 3'd1;
        in_sh_q <= in_byte;
        case (state_q)
          ST_OPC: begin
            if (byte_end) begin
              cmd_q <= in_byte;
              if (busy && (in_byte != `SEPR_OP_STATUS_READ)) begin
                state_q <= ST_IGN;
              end else begin
                case (in_byte)
                  `SEPR_OP_WRITE_ENABLE:  state_q <= ST_WAIT;
                  `SEPR_OP_WRITE_DISABLE: state_q <= ST_WAIT;
                  `SEPR_OP_STATUS_READ:   state_q <= ST_SRD;
                  `SEPR_OP_STATUS_WRITE:  state_q <= ST_SWR;
                  `SEPR_OP_ARRAY_WRITE:   state_q <= ST_ADR;
                  `SEPR_OP_ARRAY_READ:    state_q <= ST_IGN;
                  default:                state_q <= ST_IGN;
                endcase
              end
            end
          end
          ST_SWR: begin
            if (byte_end) begin
              pend_q  <= in_byte;
              state_q <= ST_WAIT;
            end
          end
          ST_ADR: begin
            if (byte_end) begin
              adr_hi_q <= 1'b1;
              if (!adr_hi_q) begin
                addr_q[15:8] <= in_byte;
              end else begin
                addr_q[7:0] <= in_byte;
                state_q     <= ST_DAT;
              end
            end
          end
          ST_DAT: begin
            if (byte_end) begin
              got_data_q <= 1'b1;
              byte_q     <= in_byte;
              byte_vld_q <= 1'b1;
            end
          end
          ST_WAIT: begin
            // A clock past the byte boundary spoils the command
            state_q <= ST_IGN;
          end
          ST_SRD: begin
            state_q <= ST_SRD;
          end
          ST_IGN: begin
            state_q <= ST_IGN;
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Write latch and non-volatile protection bits
  // --------------------------------------------------------------------
  // Flops stand in for the non-volatile cells; reset gives delivery state.
  // Enable is refused while busy, so set and cycle-end clear never meet.
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      latch_q   <= 1'b0;
      lock_q    <= STATUS_RST[`SEPR_SB_LOCK];
      guard_q   <= {STATUS_RST[`SEPR_SB_GUARD_HI], STATUS_RST[`SEPR_SB_GUARD_LO]};
      wr_kind_q <= 1'b0;
      go_q      <= 1'b0;
    end else begin
      go_q <= start_awr;
      if (start_swr | start_awr) begin
        wr_kind_q <= start_swr;
      end
      if (done) begin
        latch_q <= 1'b0;
        if (wr_kind_q) begin
          // Only b7 and b3:b2 are written; old values held until now
          lock_q  <= pend_q[`SEPR_SB_LOCK];
          guard_q <= {pend_q[`SEPR_SB_GUARD_HI], pend_q[`SEPR_SB_GUARD_LO]};
        end
      end else if (cs_rise && (state_q == ST_WAIT)) begin
        if (cmd_q == `SEPR_OP_WRITE_ENABLE) begin
          latch_q <= 1'b1;
        end else if (cmd_q == `SEPR_OP_WRITE_DISABLE) begin
          latch_q <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Status output shifter
  // --------------------------------------------------------------------
  // Snapshot at each byte start keeps one byte coherent while it shifts
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      miso_q    <= 1'b0;
      osh_q     <= 8'h00;
      out_cnt_q <= 3'd0;
    end else if (state_q != ST_SRD) begin
      out_cnt_q <= 3'd0;
    end else if (sclk_fall) begin
      out_cnt_q <= out_cnt_q + 3'd1;
      if (out_cnt_q == 3'd0) begin
        osh_q  <= status;
        miso_q <= status[7];
      end else begin
        miso_q <= osh_q[3'd7 - out_cnt_q];
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // Driver only on during status read, so an ignored command floats it
  assign spi_miso_o          = miso_q;
  assign spi_miso_oe_o       = (state_q == ST_SRD);
  assign array_wr_go_o       = go_q;
  assign array_wr_addr_o     = addr_q;
  assign array_wr_byte_o     = byte_q;
  assign array_wr_byte_vld_o = byte_vld_q;
  assign status_o            = status;
  assign hw_lock_o           = hw_lock;

endmodule

`default_nettype wire

// ---- sepr_cp_properties.sv ----
// Assertion checker for the command and protection block
`timescale 1ns/1ps
`default_nettype none

module sepr_cp_properties #(
  parameter TW_CYCLES = 400
) (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        resetn_i,
  // Pins
  input wire logic        spi_sclk_i,
  input wire logic        spi_cs_n_i,
  input wire logic        spi_mosi_i,
  input wire logic        spi_miso_o,
  input wire logic        spi_miso_oe_o,
  input wire logic        write_protect_n_i,
  // Array hand-off and status
  input wire logic        array_wr_go_o,
  input wire logic [15:0] array_wr_addr_o,
  input wire logic [7:0]  array_wr_byte_o,
  input wire logic        array_wr_byte_vld_o,
  input wire logic [7:0]  status_o,
  input wire logic        hw_lock_o
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [15:0] busy_cnt_q;
  logic        guarded;

  // Counts busy cycles so the length check needs no long repetition
  always @(posedge clock_i) begin
    if (!resetn_i) busy_cnt_q <= 16'h0000;
    else if (status_o[0]) busy_cnt_q <= busy_cnt_q + 16'h0001;
    else busy_cnt_q <= 16'h0000;
  end

  // Address lies in the region picked by the guard pair
  assign guarded = (status_o[3:2] == 2'b11) || (status_o[3] && array_wr_addr_o[15]) ||
                   (status_o[3:2] == 2'b01 && array_wr_addr_o[15:14] == 2'b11);

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence s_cycle_end;
    status_o[0] ##1 !status_o[0];
  endsequence
  sequence s_locked3;
    (status_o[7] && !write_protect_n_i) [*3];
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_oe_deselected: assert property (spi_cs_n_i [*5] |-> !spi_miso_oe_o)
    else $error("miso driven while deselected");
  a_zero_bits: assert property (status_o[6:4] == 3'b000)
    else $error("unused status bits not zero");
  a_lock_enter: assert property (s_locked3 |-> hw_lock_o)
    else $error("lock mode not entered");
  a_lock_exit: assert property (write_protect_n_i [*3] |-> !hw_lock_o)
    else $error("lock mode held with pin high");
  a_busy_len: assert property ($fell(status_o[0]) |-> busy_cnt_q == 16'(TW_CYCLES))
    else $error("write cycle length wrong");
  a_latch_drop: assert property (s_cycle_end |-> !status_o[1])
    else $error("latch not cleared at cycle end");
  a_bits_frozen: assert property (status_o[0] && $past(status_o[0]) |-> $stable(status_o[7:1]))
    else $error("status changed during write cycle");
  a_go_latch: assert property (array_wr_go_o |-> status_o[1:0] == 2'b11 && !$past(status_o[0]))
    else $error("array write started without latch");
  a_go_guard: assert property (array_wr_go_o |-> !guarded)
    else $error("array write into guarded region");
  a_busy_latch: assert property ($rose(status_o[0]) |-> status_o[1])
    else $error("cycle started with latch clear");
  a_latch_cs: assert property ($rose(status_o[1]) |-> $past(spi_cs_n_i, 2))
    else $error("latch set while selected");
endmodule

bind sepr_command_protect sepr_cp_properties #(.TW_CYCLES(TW_CYCLES)) u_props (
  .clock_i(clock_i), .resetn_i(resetn_i), .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i),
  .spi_mosi_i(spi_mosi_i), .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o),
  .write_protect_n_i(write_protect_n_i), .array_wr_go_o(array_wr_go_o),
  .array_wr_addr_o(array_wr_addr_o), .array_wr_byte_o(array_wr_byte_o),
  .array_wr_byte_vld_o(array_wr_byte_vld_o), .status_o(status_o), .hw_lock_o(hw_lock_o));

`default_nettype wire

// ---- sepr_spi_master.sv ----
// Serial bus master model driving the device pins
`timescale 1ns/1ps
`default_nettype none

module sepr_spi_master (
  // Clock
  input wire logic clock_i,
  // Pins
  input wire logic miso_i,
  output logic     sclk_o,
  output logic     cs_n_o,
  output logic     mosi_o
);
  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  logic cpol;

  initial begin
    cpol = 1'b0;
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Half of a 160 ns link period
  task automatic half;
    repeat (4) @(negedge clock_i);
  endtask

  // Idle level changes only while deselected
  task automatic set_mode(input logic p);
    @(negedge clock_i);
    cpol = p;
    sclk_o = p;
    repeat (6) @(negedge clock_i);
  endtask

  // Sends n bits of d, first byte is the opcode, MSB first
  task automatic xfer(input logic [31:0] d, input int n, output logic [15:0] rd);
    int i;
    rd = 16'h0000;
    @(negedge clock_i);
    sclk_o = cpol;
    cs_n_o = 1'b0;
    half();
    for (i = 0; i < n; i++) begin
      sclk_o = 1'b0;
      mosi_o = d[31-i];
      half();
      sclk_o = 1'b1;
      rd = {rd[14:0], miso_i};
      half();
    end
    sclk_o = cpol;
    mosi_o = ~mosi_o; // Released line has no pull
    half();
    cs_n_o = 1'b1;
    repeat (6) @(negedge clock_i);
  endtask
endmodule

`default_nettype wire

// ---- test_serial_eeprom_command_protect.sv ----
// Self-checking bench for the command and protection block
`timescale 1ns/1ps
`default_nettype none

module test_serial_eeprom_command_protect;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int TW = 400;
  logic        clock_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        write_protect_n_i = 1'b1;
  wire         sclk, cs_n, mosi, miso, miso_oe, go, lock, vld;
  wire  [15:0] waddr;
  wire  [7:0]  wbyte, status;
  logic [15:0] rd, go_addr;
  logic [7:0]  go_byte;
  logic [7:0]  bad [3] = '{8'haa, 8'h03, 8'hff};
  int          fail_count = 0, compares = 0, go_cnt = 0, oe_cnt = 0, cyc = 0, n0;
  int          vld_cnt = 0;
  // Released data line shows the inverse of its last value, never a stale copy
  wire         miso_w = miso_oe ? miso : ~miso;

  sepr_command_protect #(.TW_CYCLES(TW), .TW_CW(24)) DUT (
    .clock_i(clock_i), .resetn_i(resetn_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
    .write_protect_n_i(write_protect_n_i), .array_wr_go_o(go), .array_wr_addr_o(waddr),
    .array_wr_byte_o(wbyte), .array_wr_byte_vld_o(vld), .status_o(status), .hw_lock_o(lock));
  sepr_spi_master M (.clock_i(clock_i), .miso_i(miso_w), .sclk_o(sclk), .cs_n_o(cs_n),
    .mosi_o(mosi));

  always #10 clock_i = ~clock_i;

  // Monitor of write starts, drive time and the hang limit
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (vld === 1'b1) vld_cnt <= vld_cnt + 1;
    if (miso_oe === 1'b1) oe_cnt <= oe_cnt + 1;
    if (go === 1'b1) begin
      go_cnt <= go_cnt + 1;
      go_addr <= waddr;
      go_byte <= wbyte;
    end
    if (cyc == 30000) begin
      fail_count++;
      $display("ERROR %0t: run timed out", $time);
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic st(input logic [7:0] e);
    check({8'h00, status}, {8'h00, e});
  endtask
  task automatic cmd(input logic [31:0] d, input int n);
    M.xfer(d, n, rd);
  endtask
  // Bounded wait for the write cycle to finish
  task automatic wait_idle;
    int i;
    for (i = 0; i < 2000 && status[0] !== 1'b0; i++) @(negedge clock_i);
    check({15'h0000, status[0]}, 16'h0000);
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clock_i);
    resetn_i = 1'b1;
    st(8'h00);
    cmd({8'h05, 24'h0}, 16);
    check({8'h00, rd[7:0]}, 16'h0000);
    n0 = oe_cnt;
    foreach (bad[i]) cmd({bad[i], 8'h06, 16'h0000}, 24);
    check(16'(oe_cnt - n0), 16'h0000);
    st(8'h00);
    cmd({8'h06, 24'h0}, 8);
    st(8'h02);
    cmd({8'h04, 24'h0}, 8);
    st(8'h00);
    cmd({8'h01, 8'hff, 16'h0}, 16);
    st(8'h00);
    cmd({8'h06, 24'h0}, 8);
    cmd({8'h01, 8'hff, 16'h0}, 9);
    st(8'h02);
    // Read during the cycle: old guard values, busy and latch set
    cmd({8'h01, 8'hff, 16'h0}, 16);
    cmd({8'h05, 24'h0}, 16);
    check({8'h00, rd[7:0]}, 16'h0003);
    wait_idle();
    st(8'h8c);
    M.set_mode(1'b1);
    cmd({8'h05, 24'h0}, 24);
    check(rd, 16'h8c8c);
    @(negedge clock_i) write_protect_n_i = 1'b0;
    repeat (4) @(negedge clock_i);
    check({15'h0000, lock}, 16'h0001);
    cmd({8'h06, 24'h0}, 8);
    cmd({8'h01, 8'h00, 16'h0}, 16);
    st(8'h8e);
    cmd({8'h02, 16'h0000, 8'h55}, 32);
    check(go_cnt[15:0], 16'h0000);
    @(negedge clock_i) write_protect_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    check({15'h0000, lock}, 16'h0000);
    cmd({8'h01, 8'h84, 16'h0}, 16);
    wait_idle();
    st(8'h84);
    cmd({8'h06, 24'h0}, 8);
    cmd({8'h02, 16'hc000, 8'h55}, 32);
    check(go_cnt[15:0], 16'h0000);
    cmd({8'h02, 16'hbfff, 8'ha5}, 32);
    check(go_cnt[15:0], 16'h0001);
    check(go_addr, 16'hbfff);
    check({8'h00, go_byte}, 16'h00a5);
    check(vld_cnt[15:0], 16'h0003);
    wait_idle();
    st(8'h84);
    cmd({8'h02, 16'h0000, 8'h11}, 32);
    check(go_cnt[15:0], 16'h0001);
    wrap_up();
  end
endmodule

`default_nettype wire
